// ---- rtl/ccs_clock_ctrl.sv ----
`timescale 1ns/1ps
module ccs_clock_ctrl
  import ccs_pkg::*;
#(
  parameter int XTAL_EDGES = XTAL_SETTLE_EDGES,
  parameter int PER_W      = 16
) (
  input  wire logic       CLOCK_I,
  input  wire logic       RESET_I,
  input  wire logic       INT_OSC_I,
  input  wire logic       EXT_OSC_I,
  input  wire logic       INT_OSC_EN_I,
  input  wire logic       EXT_OSC_EN_I,
  input  wire logic [1:0] CLK_SRC_SEL_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  input  wire logic [7:0] SFR_WDATA_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            SYSCLK_O,
  output logic            PERIPH_EXT_CLK_O,
  output logic            CRYSTAL_VALID_O,
  output logic            MUL_READY_O
);

  localparam int XW = $clog2(XTAL_EDGES + 1);

  // ============================================================
  // state
  typedef struct packed {
    logic          int_s1;
    logic          int_s2;
    logic          ext_s1;
    logic          ext_s2;
    logic          int_half;
    logic          ext_half;
    logic          ext_prev;
    logic          int_prev;
    logic          mul_en;
    logic          mul_init;
    logic [1:0]    mul_sel;
    logic          init_pulse;
    logic          mul_src;
    logic [XW-1:0] xt_cnt;
    logic          xt_valid;
    logic [1:0]    sel_act;
    logic          sysclk;
    logic          periph;
    logic [7:0]    rdata;
    logic          mul_rdy;
  } ccs_ctrl_state_t;

  ccs_ctrl_state_t s;
  ccs_ctrl_state_t next_s;
  ccs_mul_if       mif ();

  ccs_mult #(
    .PER_W (PER_W)
  ) u_mult (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .m     (mif.mul)
  );

  assign mif.en         = s.mul_en;
  assign mif.init_pulse = s.init_pulse;
  assign mif.src        = s.mul_src;

  // level of a system clock source; the multiplier is held low until
  // it reports ready so a half-locked clock never reaches the core
  function automatic logic src_level(input logic [1:0] sel,
                                     input logic int_l,
                                     input logic ext_l,
                                     input logic mul_l,
                                     input logic mul_ok);
    logic lvl;
    lvl = 1'b0;
    case (sel)
      SYS_SRC_INT: lvl = int_l;
      SYS_SRC_EXT: lvl = ext_l;
      SYS_SRC_MUL: lvl = mul_l & mul_ok;
      default:     lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // ============================================================
  // next state
  always_comb begin
    logic int_l;
    logic wr_hit;
    logic want_lvl;
    int_l    = 1'b0;
    wr_hit   = 1'b0;
    want_lvl = 1'b0;
    next_s   = s;

    // pins pass two flops before any use
    next_s.int_s1 = INT_OSC_I;
    next_s.int_s2 = s.int_s1;
    next_s.ext_s1 = EXT_OSC_I;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_prev = s.ext_s2;
    next_s.int_prev = s.int_s2;
    int_l = s.int_s2 & INT_OSC_EN_I;

    // halves toggle on each rising edge of their source, the internal one only while INT_OSC_EN_I is set; only the
    // second flop is read so a metastable first stage never leaks
    if (INT_OSC_EN_I && s.int_s2 && !s.int_prev) begin
      next_s.int_half = ~s.int_half;
    end
    if (s.ext_s2 && !s.ext_prev) begin
      next_s.ext_half = ~s.ext_half;
    end

    // multiplier input mux, reserved code feeds nothing
    case (s.mul_sel)
      MSEL_HALF_INT: next_s.mul_src = s.int_half;
      MSEL_EXT:      next_s.mul_src = s.ext_s2;
      MSEL_HALF_EXT: next_s.mul_src = s.ext_half;
      default:       next_s.mul_src = 1'b0;
    endcase

    // control register write
    wr_hit = SFR_WR_I && (SFR_ADDR_I == CCS_MUL_CTRL_ADDR);
    next_s.init_pulse = 1'b0;
    if (wr_hit) begin
      next_s.mul_en   = SFR_WDATA_I[MUL_EN_BIT];
      next_s.mul_init = SFR_WDATA_I[MUL_INIT_BIT];
      next_s.mul_sel  = SFR_WDATA_I[MUL_SEL_LSB +: 2];
      // init counts only if the multiplier was enabled before this write
      next_s.init_pulse = SFR_WDATA_I[MUL_INIT_BIT]
                        & SFR_WDATA_I[MUL_EN_BIT] & s.mul_en;
    end

    // crystal settle: count source edges while enabled
    if (!EXT_OSC_EN_I) begin
      next_s.xt_cnt   = '0;
      next_s.xt_valid = 1'b0;
    end else if (s.ext_s2 && !s.ext_prev && !s.xt_valid) begin
      next_s.xt_cnt = XW'(s.xt_cnt + 1'b1);
      if (s.xt_cnt == XW'(XTAL_EDGES - 1)) begin
        next_s.xt_valid = 1'b1;
      end
    end

    // glitch-free switch: move only while both old and new are low
    want_lvl = src_level(CLK_SRC_SEL_I, int_l, s.ext_s2,
                         mif.out_clk, mif.ready);
    if (CLK_SRC_SEL_I != s.sel_act && !s.sysclk && !want_lvl) begin
      next_s.sel_act = CLK_SRC_SEL_I;
    end
    next_s.sysclk = src_level(next_s.sel_act, int_l, s.ext_s2,
                              mif.out_clk, mif.ready);
    next_s.periph  = s.ext_s2;
    next_s.mul_rdy = mif.ready;

    // registered read, reserved bits and unmapped reads give zero
    next_s.rdata = 8'h00;
    if (SFR_RD_I && SFR_ADDR_I == CCS_MUL_CTRL_ADDR) begin
      next_s.rdata[MUL_EN_BIT]        = s.mul_en;
      next_s.rdata[MUL_INIT_BIT]      = s.mul_init;
      next_s.rdata[MUL_RDY_BIT]       = mif.ready;
      next_s.rdata[MUL_SEL_LSB +: 2]  = s.mul_sel;
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign SFR_RDATA_O      = s.rdata;
  assign SYSCLK_O         = s.sysclk;
  assign PERIPH_EXT_CLK_O = s.periph;
  assign CRYSTAL_VALID_O  = s.xt_valid;
  assign MUL_READY_O      = s.mul_rdy;

  // ============================================================
  // checks
  property p_init_gate;
    @(posedge CLOCK_I) disable iff (RESET_I)
      (SFR_WR_I && SFR_ADDR_I == CCS_MUL_CTRL_ADDR && !s.mul_en)
      |=> !s.init_pulse;
  endproperty
  a_init_gate: assert property (p_init_gate)
    else $error("init accepted while multiplier was off");

  property p_rd_ready;
    @(posedge CLOCK_I) disable iff (RESET_I)
      (SFR_RD_I && SFR_ADDR_I == CCS_MUL_CTRL_ADDR)
      |=> (SFR_RDATA_O[MUL_RDY_BIT] == $past(mif.ready)
           && SFR_RDATA_O[4:2] == 3'h0);
  endproperty
  a_rd_ready: assert property (p_rd_ready)
    else $error("read data does not show ready state");

  property p_off_not_ready;
    @(posedge CLOCK_I) disable iff (RESET_I)
      !s.mul_en |=> ##1 !MUL_READY_O;
  endproperty
  a_off_not_ready: assert property (p_off_not_ready)
    else $error("ready shown while multiplier disabled");

  property p_xt_set;
    @(posedge CLOCK_I) disable iff (RESET_I)
      $rose(CRYSTAL_VALID_O) |-> $past(EXT_OSC_EN_I)
        && $past(s.xt_cnt) == XW'(XTAL_EDGES - 1);
  endproperty
  a_xt_set: assert property (p_xt_set)
    else $error("crystal valid set before settle count");

  property p_xt_clear;
    @(posedge CLOCK_I) disable iff (RESET_I)
      !EXT_OSC_EN_I |=> !CRYSTAL_VALID_O;
  endproperty
  a_xt_clear: assert property (p_xt_clear)
    else $error("crystal valid kept with oscillator off");

  property p_sys_ext;
    @(posedge CLOCK_I) disable iff (RESET_I)
      (s.sel_act == SYS_SRC_EXT && next_s.sel_act == SYS_SRC_EXT)
      |=> SYSCLK_O == $past(s.ext_s2);
  endproperty
  a_sys_ext: assert property (p_sys_ext)
    else $error("system clock does not follow external oscillator");

  property p_periph;
    @(posedge CLOCK_I) disable iff (RESET_I)
      ##1 PERIPH_EXT_CLK_O == $past(s.ext_s2);
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral clock lost the external oscillator");

  property p_switch_low;
    @(posedge CLOCK_I) disable iff (RESET_I)
      $changed(s.sel_act) |-> !SYSCLK_O && !$past(SYSCLK_O);
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("clock switched while high");

endmodule

// ---- rtl/ccs_mul_if.sv ----
`timescale 1ns/1ps
// ============================================================
// control side to multiplier core
interface ccs_mul_if;
  logic en;
  logic init_pulse;
  logic src;
  logic out_clk;
  logic ready;
  modport ctrl (output en, init_pulse, src, input out_clk, ready);
  modport mul  (input en, init_pulse, src, output out_clk, ready);
endinterface

// ---- rtl/ccs_mult.sv ----
`timescale 1ns/1ps
// ============================================================
// digital x4 multiplier: measures the input period, then emits
// eight half periods per input period, re-phased at each rising input edge
module ccs_mult
  import ccs_pkg::*;
#(
  parameter int PER_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ccs_mul_if.mul   m
);

  typedef struct packed {
    ccs_mul_state_t st;
    logic           prev;
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] nco;
    logic           out;
    logic [1:0]     match;
    logic           ready;
    logic [3:0]     tog;
  } ccs_mult_state_t;

  ccs_mult_state_t s;
  ccs_mult_state_t next_s;

  always_comb begin
    logic             rise;
    logic [PER_W-1:0] meas;
    logic [PER_W-1:0] diff;
    logic             close;
    rise   = 1'b0;
    meas   = '0;
    diff   = '0;
    close  = 1'b0;
    next_s = s;
    rise        = m.src & ~s.prev;
    next_s.prev = m.src;
    meas        = PER_W'(s.cnt + 1'b1);
    diff        = (meas > s.per) ? PER_W'(meas - s.per)
                                 : PER_W'(s.per - meas);
    close = (diff <= PER_W'(MUL_PER_TOL))
          && (meas >= PER_W'(MUL_HALF_STEPS));
    if (s.cnt != '1) begin
      next_s.cnt = PER_W'(s.cnt + 1'b1);
    end
    case (s.st)
      MUL_OFF: begin
        if (m.en) begin
          next_s.st = MUL_ARMED;
        end
      end
      MUL_ARMED: begin
        if (m.init_pulse) begin
          next_s.st    = MUL_LOCK;
          next_s.match = '0;
        end
      end
      MUL_LOCK, MUL_RUN: begin
        if (rise) begin
          next_s.cnt = '0;
          next_s.per = meas;
          next_s.nco = PER_W'((meas >> MUL_PER_SHIFT) - 1'b1);
          next_s.out = 1'b1;
          next_s.tog = '0;
          if (!close) begin
            next_s.match = '0;
          end else if (s.match != 2'(MUL_LOCK_MATCH)) begin
            next_s.match = 2'(s.match + 1'b1);
          end
        end else if (s.nco == '0) begin
          next_s.out = ~s.out;
          next_s.nco = PER_W'((s.per >> MUL_PER_SHIFT) - 1'b1);
          next_s.tog = 4'(s.tog + 1'b1);
        end else begin
          next_s.nco = PER_W'(s.nco - 1'b1);
        end
        // a stalled input loses lock
        if (s.cnt == '1) begin
          next_s.match = '0;
          next_s.out   = 1'b0;
        end
        if (m.init_pulse) begin
          next_s.match = '0;
        end
        next_s.ready = (next_s.match == 2'(MUL_LOCK_MATCH));
        next_s.st    = next_s.ready ? MUL_RUN : MUL_LOCK;
      end
      default: begin
        next_s.st = MUL_OFF;
      end
    endcase
    if (!m.en) begin
      next_s.st    = MUL_OFF;
      next_s.out   = 1'b0;
      next_s.ready = 1'b0;
      next_s.match = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign m.out_clk = s.out;
  assign m.ready   = s.ready;

  property p_mul_ratio;
    @(posedge clk_i) disable iff (rst_i)
      (s.st == MUL_RUN && m.src && !s.prev && s.cnt < s.per
       && s.cnt + 2 >= s.per)
      |-> (s.tog == 4'h7 || s.tog == 4'h8);
  endproperty
  a_mul_ratio: assert property (p_mul_ratio)
    else $error("multiplier did not give four cycles per input");

  property p_mul_ready;
    @(posedge clk_i) disable iff (rst_i)
      m.ready |-> (s.st == MUL_RUN && s.match == 2'(MUL_LOCK_MATCH));
  endproperty
  a_mul_ready: assert property (p_mul_ready)
    else $error("ready without lock");

endmodule

// ---- rtl/ccs_pkg.sv ----
// ============================================================
// clock control constants
package ccs_pkg;

  // ============================================================
  // register map
  localparam logic [7:0] CCS_MUL_CTRL_ADDR  = 8'hBE;
  localparam logic [7:0] CCS_MUL_CTRL_RESET = 8'h00;
  localparam int         MUL_EN_BIT         = 7;
  localparam int         MUL_INIT_BIT       = 6;
  localparam int         MUL_RDY_BIT        = 5;
  localparam int         MUL_SEL_LSB        = 0;

  // ============================================================
  // source encodings
  localparam logic [1:0] MSEL_HALF_INT = 2'h0;
  localparam logic [1:0] MSEL_EXT      = 2'h1;
  localparam logic [1:0] MSEL_HALF_EXT = 2'h2;
  localparam logic [1:0] SYS_SRC_INT   = 2'h0;
  localparam logic [1:0] SYS_SRC_EXT   = 2'h1;
  localparam logic [1:0] SYS_SRC_MUL   = 2'h2;

  // ============================================================
  // multiplier and settle counts
  localparam int MUL_FACTOR     = 4;
  localparam int MUL_HALF_STEPS = 2 * MUL_FACTOR;
  localparam int MUL_PER_SHIFT  = $clog2(MUL_HALF_STEPS);
  localparam int MUL_PER_TOL    = 2;
  localparam int MUL_LOCK_MATCH = 2;
  localparam int XTAL_SETTLE_EDGES = 1024;

  typedef enum logic [1:0] {
    MUL_OFF,
    MUL_ARMED,
    MUL_LOCK,
    MUL_RUN
  } ccs_mul_state_t;

endpackage

// ---- test/test_clock_multiplier_and_sysclk_select.sv ----
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the clock control block
module test_clock_multiplier_and_sysclk_select;
  import ccs_pkg::*;

  localparam int XE = 4;
  localparam int W  = 256;

  logic       clk     = 1'b0;
  logic       rst     = 1'b1;
  logic       int_osc = 1'b0;
  logic       ext_osc = 1'b0;
  logic       int_en  = 1'b1;
  logic       ext_en  = 1'b0;
  logic [1:0] src_sel = 2'h0;
  logic [7:0] addr    = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] wdata   = 8'h00;
  logic [7:0] rdata;
  logic       sysclk;
  logic       per_clk;
  logic       xvalid;
  logic       mrdy;
  int         ih = 8;
  int         eh = 8;
  int         ic = 0;
  int         ec = 0;
  int         cyc = 0;
  int         mismatches = 0;
  int         cmp_count = 0;

  ccs_clock_ctrl #(.XTAL_EDGES(XE)) i_dut (
    .CLOCK_I(clk), .RESET_I(rst), .INT_OSC_I(int_osc),
    .EXT_OSC_I(ext_osc), .INT_OSC_EN_I(int_en), .EXT_OSC_EN_I(ext_en),
    .CLK_SRC_SEL_I(src_sel), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
    .SYSCLK_O(sysclk), .PERIPH_EXT_CLK_O(per_clk),
    .CRYSTAL_VALID_O(xvalid), .MUL_READY_O(mrdy));

  always #2 clk = ~clk;

  // ============================================================
  // oscillators, stepped on the falling edge like all stimulus
  always @(negedge clk) begin
    ic <= (ic >= ih - 1) ? 0 : ic + 1;
    ec <= (ec >= eh - 1) ? 0 : ec + 1;
    if (ic >= ih - 1) begin
      int_osc <= ~int_osc;
    end
    if (ec >= eh - 1) begin
      ext_osc <= ~ext_osc;
    end
  end

  // whole run is about ten thousand cycles; this ceiling only catches hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end

  // ============================================================
  // shared tasks
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    d    = rdata;
  endtask

  // counts rising edges of the system and peripheral clocks
  task automatic count_rises(input int n, output int cs, output int cp);
    logic ps;
    logic pp;
    cs = 0;
    cp = 0;
    ps = sysclk;
    pp = per_clk;
    repeat (n) begin
      @(negedge clk);
      if (sysclk === 1'b1 && ps === 1'b0) cs++;
      if (per_clk === 1'b1 && pp === 1'b0) cp++;
      ps = sysclk;
      pp = per_clk;
    end
  endtask

  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction

  // period in system cycles of the clock fed to the multiplier
  function automatic int mul_in_period(input logic [1:0] s);
    if (s == MSEL_HALF_INT) return 4 * ih;
    if (s == MSEL_EXT) return 2 * eh;
    return 4 * eh;
  endfunction

  // ============================================================
  // main sequence
  initial begin
    int          cs;
    int          cp;
    int          p;
    logic [7:0]  d;
    logic [7:0]  r;
    logic [1:0]  s;
    logic        ok;
    int          halves[3] = '{8, 12, 16};
    void'($urandom(40));
    ih = halves[$urandom % 3];
    eh = halves[$urandom % 3];
    repeat (4) @(negedge clk);
    rst = 1'b0;

    reg_rd(CCS_MUL_CTRL_ADDR, r);
    check("ctrl_reset", r, CCS_MUL_CTRL_RESET);
    repeat (4) begin
      d = 8'($urandom) & 8'h7F;
      reg_wr(CCS_MUL_CTRL_ADDR, d);
      reg_wr(8'hBD, 8'hFF);
      reg_rd(CCS_MUL_CTRL_ADDR, r);
      check("ctrl_rw", r, {1'b0, d[6], 4'h0, d[1:0]});
      reg_rd(8'hBF, r);
      check("unmapped", r, 8'h00);
    end
    $display("test registers done");

    ext_en = 1'b1;
    // settle wait shrunk along with the short edge count
    repeat ((XE + 4) * 2 * eh) @(negedge clk);
    check("xtal_valid", {7'h0, xvalid}, 8'h01);
    ext_en = 1'b0;
    repeat (2) @(negedge clk);
    check("xtal_cleared", {7'h0, xvalid}, 8'h00);
    ext_en = 1'b1;
    repeat ((XE + 4) * 2 * eh) @(negedge clk);
    $display("test crystal done");

    src_sel = SYS_SRC_INT;
    repeat (32) @(negedge clk);
    count_rises(W, cs, cp);
    check("int_sys", 8'(near(cs, W / (2 * ih), 1)), 8'h01);
    check("periph", 8'(near(cp, W / (2 * eh), 1)), 8'h01);
    src_sel = SYS_SRC_EXT;
    // both sources must be low together before the switch moves
    repeat (64) @(negedge clk);
    count_rises(W, cs, cp);
    check("ext_sys", 8'(near(cs, W / (2 * eh), 1)), 8'h01);
    int_en  = 1'b0;
    src_sel = SYS_SRC_INT;
    repeat (32) @(negedge clk);
    count_rises(W, cs, cp);
    check("int_off", 8'(cs), 8'h00);
    check("int_off_lvl", {7'h0, sysclk}, 8'h00);
    int_en = 1'b1;
    $display("test system clock done");

    foreach (halves[k]) begin
      s = 2'(k);
      reg_wr(CCS_MUL_CTRL_ADDR, 8'h00);
      reg_wr(CCS_MUL_CTRL_ADDR, {6'h00, s});
      reg_wr(CCS_MUL_CTRL_ADDR, {6'h20, s});
      repeat (1300) @(negedge clk);
      reg_wr(CCS_MUL_CTRL_ADDR, {6'h30, s});
      r = 8'h00;
      for (int i = 0; i < 300 && r[5] !== 1'b1; i++) begin
        reg_rd(CCS_MUL_CTRL_ADDR, r);
      end
      check("mul_ready_bit", r, {6'h38, s});
      check("mul_ready_pin", {7'h0, mrdy}, 8'h01);
      src_sel = SYS_SRC_MUL;
      repeat (64) @(negedge clk);
      p = mul_in_period(s);
      count_rises(8 * p, cs, cp);
      ok = near(cs, 8 * MUL_FACTOR, 2);
      check("mul_rate", 8'(ok), 8'h01);
      src_sel = SYS_SRC_INT;
      repeat (32) @(negedge clk);
    end
    $display("test multiplier done");

    reg_wr(CCS_MUL_CTRL_ADDR, 8'h00);
    reg_wr(CCS_MUL_CTRL_ADDR, {6'h30, MSEL_EXT});
    src_sel = SYS_SRC_MUL;
    repeat (600) @(negedge clk);
    reg_rd(CCS_MUL_CTRL_ADDR, r);
    check("init_no_en", r, {6'h30, MSEL_EXT});
    count_rises(W, cs, cp);
    check("mul_held_low", 8'(cs), 8'h00);
    $display("test early init done");

    reg_wr(CCS_MUL_CTRL_ADDR, 8'h83);
    repeat (1300) @(negedge clk);
    reg_wr(CCS_MUL_CTRL_ADDR, 8'hC3);
    repeat (600) @(negedge clk);
    reg_rd(CCS_MUL_CTRL_ADDR, r);
    check("sel_reserved", r, 8'hC3);
    src_sel = 2'h3;
    repeat (64) @(negedge clk);
    count_rises(W, cs, cp);
    check("sys_none", 8'(cs), 8'h00);
    $display("test reserved codes done");

    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check("rst_ready", {7'h0, mrdy}, 8'h00);
    check("rst_valid", {7'h0, xvalid}, 8'h00);
    check("rst_sys", {7'h0, sysclk}, 8'h00);
    reg_rd(CCS_MUL_CTRL_ADDR, r);
    check("rst_ctrl", r, CCS_MUL_CTRL_RESET);
    $display("test reset done");
    final_report();
  end

endmodule
